// >>> inc/tmc_defines.svh
// Register offsets, field positions, reset values and the rule overview.
// Overview of operation
// - Control bit 7 selects 16-bit buffered access.
// - Control bit 6 reads system-clock-from-oscillator status.
// - Bits 5:4 divide input by 1,2,4,8.
// - Bit 3 enables low-power oscillator, else off.
// - Bit 2 bypasses external sync; ignored internally. The code still samples the input and only selects async mode.
// - Bit 1 picks external pin or internal clock.
// - Bit 0 runs counter; stop holds value.
// - Timer, sync counter and async counter modes.
// - Enabled timer forces pins input, reads zero.
// - Low byte read copies high byte to buffer.
// - High write fills buffer; low write loads both.
// - Live high byte only via buffer in wide mode.
// - Low-byte write clears prescaler; high write doesn't.
// - Oscillator keeps running through power-managed modes.
// - Count wraps FFFF to 0000, latching overflow flag.
// - Compare reset clears count except in async mode; write wins; no flag.
// - Async mode arms next count on falling edge.
`ifndef TMC_DEFINES_SVH
`define TMC_DEFINES_SVH
`define TMC_ADDR_W        3
`define TMC_OFS_CTRL      3'h0
`define TMC_OFS_LO        3'h1
`define TMC_OFS_HI        3'h2
`define TMC_OFS_FLAG      3'h3
`define TMC_CTRL_RST      7'h00
`define TMC_BIT_WIDE      7
`define TMC_BIT_SYSCLK    6
`define TMC_BIT_PS_HI     5
`define TMC_BIT_PS_LO     4
`define TMC_BIT_OSC       3
`define TMC_BIT_BYPASS    2
`define TMC_BIT_EXT       1
`define TMC_BIT_RUN       0
`define TMC_BIT_OVF       0
`define TMC_BIT_OVF_IE    1
`define TMC_CNT_RST       16'h0000
`define TMC_CNT_MAX       16'hffff
`define TMC_PS_W          3
`define TMC_QTR_W         2
`define TMC_QTR_LAST      2'h3
`endif

// >>> inc/tmc_pkg.sv
// Types shared by the timer/counter core.
package tmc_pkg;
   typedef struct packed {
      logic       wide;
      logic [1:0] prescale;
      logic       osc_en;
      logic       bypass;
      logic       ext;
      logic       run;
   } tmc_ctrl_s;

   typedef enum logic [2:0] {
      TMC_TIMER = 3'h1,
      TMC_SYNC  = 3'h2,
      TMC_ASYNC = 3'h4
   } tmc_mode_e;
endpackage : tmc_pkg

// >>> core/tmc_edge_sync.sv
// Two-stage synchronizer with rising and falling edge detection.
`timescale 1ns/100ps
module tmc_edge_sync (
   // Clock and reset
   input  wire logic ref_clk,
   input  wire logic reset,
   // Raw and synchronized level
   input  wire logic raw_in,
   output logic      sync_q,
   // Edge pulses
   output logic      rise,
   output logic      fall
);
   logic meta_q;
   logic prev_q;

   always_ff @(posedge ref_clk) begin
      if (reset) begin
         meta_q <= 1'b0;
         sync_q <= 1'b0;
         prev_q <= 1'b0;
      end else begin
         meta_q <= raw_in;
         sync_q <= meta_q;
         prev_q <= sync_q;
      end
   end

   assign rise = sync_q & ~prev_q;
   assign fall = ~sync_q & prev_q;
endmodule : tmc_edge_sync

// >>> core/tmc_timer.sv
// Sixteen-bit timer/counter with prescaler and Avalon-MM registers.
`timescale 1ns/100ps
`include "tmc_defines.svh"
module tmc_timer (
   // Clock and reset
   input  wire logic                     ref_clk,
   input  wire logic                     reset,
   // Avalon-MM slave
   input  wire logic [`TMC_ADDR_W-1:0]   avs_address,
   input  wire logic                     avs_read,
   input  wire logic                     avs_write,
   input  wire logic [31:0]              avs_writedata,
   input  wire logic [3:0]               avs_byteenable,
   output logic [31:0]                   avs_readdata,
   output logic                          avs_waitrequest,
   // Clock system and compare trigger
   input  wire logic                     sysclk_from_lp_osc,
   input  wire logic                     compare_reset,
   // Pins: external clock or crystal
   input  wire logic                     ext_clk_pin,
   input  wire logic                     osc_in_pin,
   input  wire logic [1:0]               port_c_direction,
   input  wire logic [1:0]               port_c_in,
   output logic [1:0]                    port_c_oe,
   output logic [1:0]                    port_c_read,
   // Status
   output logic                          lp_osc_enable,
   output tmc_pkg::tmc_mode_e            mode,
   output logic                          overflow_flag,
   output logic                          overflow_irq
);
   import tmc_pkg::*;

   tmc_ctrl_s              ctrl_q;
   logic [15:0]            count_q;
   logic [7:0]             hi_buf_q;
   logic [`TMC_PS_W-1:0]   ps_q;
   logic [`TMC_QTR_W-1:0]  qtr_q;
   logic                   ovf_q;
   logic                   ovf_ie_q;
   logic                   armed_q;
   logic                   ack_q;
   logic [31:0]            rdata_q;
   logic                   ext_rise;
   logic                   ext_fall;
   logic                   src_edge;
   logic                   ps_tick;
   logic                   inc;
   logic                   wrap;
   logic                   access;
   logic                   wr_lo;
   logic                   wr_hi;
   logic                   rd_lo;
   logic                   wr_ctrl;
   logic                   wr_flag;
   logic [`TMC_PS_W-1:0]   ps_mask;

   // Crystal output feeds the count input when the oscillator runs.
   logic ext_raw;
   assign ext_raw = ctrl_q.osc_en ? osc_in_pin : ext_clk_pin;

   tmc_edge_sync u_sync (
      .ref_clk (ref_clk),
      .reset   (reset),
      .raw_in  (ext_raw),
      .sync_q  (),
      .rise    (ext_rise),
      .fall    (ext_fall)
   );

   // Every access answers one cycle late; the request must be held.
   // Reads are captured on the first edge so read data can come from a
   // flip-flop; writes land only on the edge that completes the transfer.
   assign access          = (avs_read | avs_write) & ~ack_q;
   assign avs_waitrequest = (avs_read | avs_write) & ~ack_q;
   assign wr_ctrl = ack_q & avs_write & avs_byteenable[0]
                    & (avs_address == `TMC_OFS_CTRL);
   assign wr_lo   = ack_q & avs_write & avs_byteenable[0]
                    & (avs_address == `TMC_OFS_LO);
   assign wr_hi   = ack_q & avs_write & avs_byteenable[0]
                    & (avs_address == `TMC_OFS_HI);
   assign wr_flag = ack_q & avs_write & avs_byteenable[0]
                    & (avs_address == `TMC_OFS_FLAG);
   assign rd_lo   = access & avs_read & (avs_address == `TMC_OFS_LO);

   always_comb begin
      if (!ctrl_q.ext) begin
         mode = TMC_TIMER;
      end else if (ctrl_q.bypass) begin
         mode = TMC_ASYNC;
      end else begin
         mode = TMC_SYNC;
      end
   end

   // Async counting is modelled on the sampled input too; the arm flag
   // waits for a falling edge after a write to either count byte before counting again.
   always_comb begin
      case (mode)
         TMC_TIMER: src_edge = (qtr_q == `TMC_QTR_LAST);
         TMC_SYNC:  src_edge = ext_rise;
         TMC_ASYNC: src_edge = ext_rise & armed_q;
         default:   src_edge = 1'b0;
      endcase
   end

   assign ps_mask = `TMC_PS_W'((1 << ctrl_q.prescale) - 1);
   assign ps_tick = src_edge & ((ps_q & ps_mask) == ps_mask);
   assign inc     = ctrl_q.run & ps_tick;
   assign wrap    = inc & (count_q == `TMC_CNT_MAX);

   always_ff @(posedge ref_clk) begin
      if (reset) begin
         ack_q <= 1'b0;
      end else begin
         ack_q <= access;
      end
   end

   // Instruction-cycle divider: one count per four reference clocks.
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         qtr_q <= '0;
      end else begin
         qtr_q <= qtr_q + `TMC_QTR_W'(1);
      end
   end

   always_ff @(posedge ref_clk) begin
      if (reset) begin
         ctrl_q <= `TMC_CTRL_RST;
      end else if (wr_ctrl) begin
         ctrl_q.wide     <= avs_writedata[`TMC_BIT_WIDE];
         ctrl_q.prescale <= avs_writedata[`TMC_BIT_PS_HI:`TMC_BIT_PS_LO];
         ctrl_q.osc_en   <= avs_writedata[`TMC_BIT_OSC];
         ctrl_q.bypass   <= avs_writedata[`TMC_BIT_BYPASS];
         ctrl_q.ext      <= avs_writedata[`TMC_BIT_EXT];
         ctrl_q.run      <= avs_writedata[`TMC_BIT_RUN];
      end
   end

   always_ff @(posedge ref_clk) begin
      if (reset) begin
         ps_q <= '0;
      end else if (wr_lo) begin
         ps_q <= '0;
      end else if (ctrl_q.run & src_edge) begin
         ps_q <= ps_q + `TMC_PS_W'(1);
      end
   end

   // Register writes take precedence over the compare reset.
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         count_q <= `TMC_CNT_RST;
      end else if (wr_lo) begin
         count_q[7:0] <= avs_writedata[7:0];
         if (ctrl_q.wide) begin
            count_q[15:8] <= hi_buf_q;
         end
      end else if (wr_hi & ~ctrl_q.wide) begin
         count_q[15:8] <= avs_writedata[7:0];
      end else if (compare_reset & (mode != TMC_ASYNC)) begin
         count_q <= `TMC_CNT_RST;
      end else if (inc) begin
         count_q <= count_q + 16'h0001;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (reset) begin
         hi_buf_q <= 8'h00;
      end else if (wr_hi & ctrl_q.wide) begin
         hi_buf_q <= avs_writedata[7:0];
      end else if (rd_lo & ctrl_q.wide) begin
         hi_buf_q <= count_q[15:8];
      end
   end

   always_ff @(posedge ref_clk) begin
      if (reset) begin
         armed_q <= 1'b1;
      end else if (wr_lo | wr_hi) begin
         armed_q <= 1'b0;
      end else if (ext_fall) begin
         armed_q <= 1'b1;
      end
   end

   // A wrap in the same cycle as a software clear keeps the flag set.
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         ovf_q    <= 1'b0;
         ovf_ie_q <= 1'b0;
      end else begin
         if (wrap) begin
            ovf_q <= 1'b1;
         end else if (wr_flag & ~avs_writedata[`TMC_BIT_OVF]) begin
            ovf_q <= 1'b0;
         end
         if (wr_flag) begin
            ovf_ie_q <= avs_writedata[`TMC_BIT_OVF_IE];
         end
      end
   end

   always_ff @(posedge ref_clk) begin
      if (reset) begin
         rdata_q <= 32'h0000_0000;
      end else if (access & avs_read) begin
         rdata_q <= 32'h0000_0000;
         case (avs_address)
            `TMC_OFS_CTRL: begin
               rdata_q[`TMC_BIT_WIDE]   <= ctrl_q.wide;
               rdata_q[`TMC_BIT_SYSCLK] <= sysclk_from_lp_osc;
               rdata_q[`TMC_BIT_PS_HI:`TMC_BIT_PS_LO] <= ctrl_q.prescale;
               rdata_q[`TMC_BIT_OSC]    <= ctrl_q.osc_en;
               rdata_q[`TMC_BIT_BYPASS] <= ctrl_q.bypass;
               rdata_q[`TMC_BIT_EXT]    <= ctrl_q.ext;
               rdata_q[`TMC_BIT_RUN]    <= ctrl_q.run;
            end
            `TMC_OFS_LO: rdata_q[7:0] <= count_q[7:0];
            `TMC_OFS_HI: rdata_q[7:0] <= ctrl_q.wide ? hi_buf_q
                                                    : count_q[15:8];
            `TMC_OFS_FLAG: begin
               rdata_q[`TMC_BIT_OVF]    <= ovf_q;
               rdata_q[`TMC_BIT_OVF_IE] <= ovf_ie_q;
            end
            default: rdata_q <= 32'h0000_0000;
         endcase
      end
   end

   assign avs_readdata = rdata_q;

   // The oscillator enable ignores any sleep state: it drops only by write or reset.
   assign lp_osc_enable = ctrl_q.osc_en;
   assign port_c_oe     = ctrl_q.run ? 2'h0 : ~port_c_direction;
   assign port_c_read   = ctrl_q.run ? 2'h0 : port_c_in;
   assign overflow_flag = ovf_q;
   assign overflow_irq  = ovf_q & ovf_ie_q;
endmodule : tmc_timer

// >>> sim/tmc_ext_src.sv
// Far-side count source: external clock pin or low-power crystal.
`timescale 1ns/100ps
module tmc_ext_src (
   // Count lines, resting low between bursts
   output logic ext_clk,
   output logic osc_clk
);
   initial {ext_clk, osc_clk} = 2'b00;
   // Rising edges only within a burst, so no stray edge is counted.
   // The burst starts off the clock grid so no edge meets a sampling edge.
   task automatic pulses(input bit osc, input int n, input int half);
      #2;
      repeat (n) begin
         #half;
         {ext_clk, osc_clk} = osc ? 2'b01 : 2'b10;
         #half;
         {ext_clk, osc_clk} = 2'b00;
      end
   endtask : pulses
endmodule : tmc_ext_src

// >>> sim/tmc_timer_checker.sv
// Concurrent checks on the timer/counter ports.
`timescale 1ns/100ps
`include "tmc_defines.svh"
module tmc_timer_checker (
   // Clock and reset
   input wire logic                   ref_clk,
   input wire logic                   reset,
   // Register bus
   input wire logic [`TMC_ADDR_W-1:0] avs_address,
   input wire logic                   avs_read,
   input wire logic                   avs_write,
   input wire logic [31:0]            avs_writedata,
   input wire logic [3:0]             avs_byteenable,
   input wire logic [31:0]            avs_readdata,
   input wire logic                   avs_waitrequest,
   // Pins and status
   input wire logic                   sysclk_from_lp_osc,
   input wire logic [1:0]             port_c_direction,
   input wire logic [1:0]             port_c_in,
   input wire logic [1:0]             port_c_oe,
   input wire logic [1:0]             port_c_read,
   input wire logic                   lp_osc_enable,
   input wire tmc_pkg::tmc_mode_e     mode,
   input wire logic                   overflow_flag,
   input wire logic                   overflow_irq
);
   import tmc_pkg::*;
   logic [7:0] ctrl_q;
   logic       ie_q;
   logic       wr_ok;
   logic       rd_ok;
   logic       run;
   assign wr_ok = avs_write && !avs_waitrequest && avs_byteenable[0];
   assign rd_ok = avs_read && !avs_waitrequest;
   assign run = ctrl_q[0];
   always_ff @(posedge ref_clk)
      if (reset) ctrl_q <= 8'h00;
      else if (wr_ok && avs_address == `TMC_OFS_CTRL)
         ctrl_q <= avs_writedata[7:0];
   always_ff @(posedge ref_clk)
      if (reset) ie_q <= 1'b0;
      else if (wr_ok && avs_address == `TMC_OFS_FLAG)
         ie_q <= avs_writedata[1];
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (reset);
   sequence s_req;
      (avs_read || avs_write) && avs_waitrequest;
   endsequence
   chk_one_wait: assert property (s_req |=> !avs_waitrequest)
      else $error("request held off for more than one cycle");
   chk_mode_sel: assert property (mode == (!ctrl_q[1] ? TMC_TIMER :
      ctrl_q[2] ? TMC_ASYNC : TMC_SYNC)) else $error("mode mismatch");
   chk_osc_follow: assert property (lp_osc_enable == ctrl_q[3])
      else $error("oscillator enable wrong");
   chk_pins_held: assert property (run |-> !port_c_oe && !port_c_read)
      else $error("pins not forced while running");
   chk_pins_free: assert property (!run |-> port_c_oe == ~port_c_direction
      && port_c_read == port_c_in) else $error("pins wrong while stopped");
   chk_status_rd: assert property (rd_ok && avs_address == `TMC_OFS_CTRL
      |-> avs_readdata[6] == $past(sysclk_from_lp_osc))
      else $error("clock status bit wrong");
   chk_unmapped_rd: assert property (rd_ok && avs_address[2]
      |-> avs_readdata == 32'h0) else $error("unmapped read not zero");
   chk_irq_gate: assert property (overflow_irq == (overflow_flag && ie_q))
      else $error("interrupt not flag and enable");
   chk_flag_cause: assert property ($rose(overflow_flag) |-> $past(run))
      else $error("overflow flag set while stopped");
endmodule : tmc_timer_checker
bind tmc_timer tmc_timer_checker tmc_timer_checker_inst (
   .ref_clk(ref_clk), .reset(reset), .avs_address(avs_address),
   .avs_read(avs_read), .avs_write(avs_write),
   .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
   .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
   .sysclk_from_lp_osc(sysclk_from_lp_osc),
   .port_c_direction(port_c_direction), .port_c_in(port_c_in),
   .port_c_oe(port_c_oe), .port_c_read(port_c_read),
   .lp_osc_enable(lp_osc_enable), .mode(mode),
   .overflow_flag(overflow_flag), .overflow_irq(overflow_irq));

// >>> sim/tmc_timer_tb.sv
// Self-checking bench for the timer/counter.
`timescale 1ns/100ps
`include "tmc_defines.svh"
module tmc_timer_tb;
   import tmc_pkg::*;
   logic        ref_clk = 1'b0, reset = 1'b1, compare_reset = 1'b0;
   logic [2:0]  avs_address = 3'h0;
   logic        avs_read = 1'b0, avs_write = 1'b0, avs_waitrequest;
   logic [31:0] avs_writedata = 32'h0, avs_readdata, seed = 32'h0001_3355;
   logic [3:0]  avs_byteenable = 4'h0;
   logic        sysclk_from_lp_osc = 1'b1, ext_clk_pin, osc_in_pin;
   logic [1:0]  port_c_direction = 2'h2, port_c_in = 2'h1;
   logic [1:0]  port_c_oe, port_c_read;
   logic        lp_osc_enable, overflow_flag, overflow_irq;
   logic [7:0]  rd;
   tmc_mode_e   mode;
   int          error_cnt = 0, num_checks = 0, cycles = 0, n, s;
   always #5 ref_clk = ~ref_clk;
   tmc_timer tmc_timer_inst (.ref_clk(ref_clk), .reset(reset),
      .avs_address(avs_address), .avs_read(avs_read),
      .avs_write(avs_write), .avs_writedata(avs_writedata),
      .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
      .avs_waitrequest(avs_waitrequest),
      .sysclk_from_lp_osc(sysclk_from_lp_osc),
      .compare_reset(compare_reset), .ext_clk_pin(ext_clk_pin),
      .osc_in_pin(osc_in_pin), .port_c_direction(port_c_direction),
      .port_c_in(port_c_in), .port_c_oe(port_c_oe),
      .port_c_read(port_c_read), .lp_osc_enable(lp_osc_enable),
      .mode(mode), .overflow_flag(overflow_flag),
      .overflow_irq(overflow_irq));
   tmc_ext_src tmc_ext_src_inst (.ext_clk(ext_clk_pin),
      .osc_clk(osc_in_pin));
   function automatic logic [31:0] xs(input logic [31:0] v);
      logic [31:0] t;
      t = v ^ (v << 13);
      t = t ^ (t >> 17);
      return t ^ (t << 5);
   endfunction : xs
   task automatic check(input logic [15:0] got, input logic [15:0] exp);
      num_checks++;
      if (got !== exp) begin
         error_cnt++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : check
   // Request held until the edge where waitrequest is low.
   task automatic bus(input logic wr, input logic [2:0] a,
                      input logic [7:0] d, input logic [3:0] be);
      @(posedge ref_clk);
      avs_address <= a;
      avs_writedata <= {24'h0, d};
      avs_byteenable <= be;
      avs_write <= wr;
      avs_read <= !wr;
      @(posedge ref_clk);
      while (avs_waitrequest) @(posedge ref_clk);
      rd = avs_readdata[7:0];
      avs_write <= 1'b0;
      avs_read <= 1'b0;
   endtask : bus
   task automatic reg_wr(input logic [2:0] a, input logic [7:0] d);
      bus(1'b1, a, d, 4'h1);
   endtask : reg_wr
   task automatic reg_rd(input logic [2:0] a, input logic [7:0] exp);
      bus(1'b0, a, 8'h00, 4'h0);
      check(rd, exp);
   endtask : reg_rd
   task automatic end_of_test();
      $display("Checks %0d, mismatches %0d", num_checks, error_cnt);
      if (error_cnt == 0 && num_checks > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask : end_of_test
   always @(posedge ref_clk) begin
      cycles++;
      if (cycles == 20000) begin
         error_cnt++;
         end_of_test();
      end
   end
   initial begin
      repeat (20) @(posedge ref_clk);
      reset <= 1'b0;
      seed = xs(seed);
      port_c_in <= seed[17:16];
      reg_rd(`TMC_OFS_CTRL, 8'h40);
      reg_wr(`TMC_OFS_CTRL, 8'hb6);
      bus(1'b1, `TMC_OFS_CTRL, 8'h01, 4'he);
      reg_rd(`TMC_OFS_CTRL, 8'hf6);
      check(mode, TMC_ASYNC);
      bus(1'b0, 3'h5, 8'h00, 4'h0);
      check(rd, 8'h00);
      $display("Control test done");
      reg_wr(`TMC_OFS_CTRL, 8'h00);
      reg_wr(`TMC_OFS_HI, seed[7:0]);
      reg_wr(`TMC_OFS_LO, seed[15:8]);
      reg_rd(`TMC_OFS_HI, seed[7:0]);
      reg_wr(`TMC_OFS_CTRL, 8'h80);
      reg_wr(`TMC_OFS_HI, 8'h5a);
      reg_rd(`TMC_OFS_HI, 8'h5a);
      reg_rd(`TMC_OFS_LO, seed[15:8]);
      reg_rd(`TMC_OFS_HI, seed[7:0]);
      reg_wr(`TMC_OFS_HI, 8'h5a);
      reg_wr(`TMC_OFS_LO, 8'h3c);
      reg_wr(`TMC_OFS_CTRL, 8'h00);
      reg_rd(`TMC_OFS_HI, 8'h5a);
      reg_rd(`TMC_OFS_LO, 8'h3c);
      $display("Access test done");
      // A window of whole prescaled periods holds a fixed count.
      for (int ps = 0; ps < 4; ps++) begin
         reg_wr(`TMC_OFS_LO, 8'h00);
         reg_wr(`TMC_OFS_HI, 8'h00);
         reg_wr(`TMC_OFS_CTRL, {2'b00, ps[1:0], 4'h1});
         repeat ((10 * 4 << ps) - 3) @(posedge ref_clk);
         check(port_c_oe, 2'b00);
         check(port_c_read, 2'b00);
         reg_wr(`TMC_OFS_CTRL, 8'h00);
         reg_rd(`TMC_OFS_LO, 8'h0a);
      end
      check(port_c_read, port_c_in);
      check(port_c_oe, {14'h0, ~port_c_direction});
      $display("Prescale test done");
      reg_wr(`TMC_OFS_HI, 8'hff);
      reg_wr(`TMC_OFS_LO, 8'hfe);
      reg_wr(`TMC_OFS_FLAG, 8'h02);
      reg_wr(`TMC_OFS_CTRL, 8'h01);
      repeat (9) @(posedge ref_clk);
      reg_wr(`TMC_OFS_CTRL, 8'h00);
      check({overflow_flag, overflow_irq}, 2'b11);
      reg_rd(`TMC_OFS_LO, 8'h01);
      reg_rd(`TMC_OFS_HI, 8'h00);
      reg_wr(`TMC_OFS_FLAG, 8'h02);
      reg_wr(`TMC_OFS_HI, 8'hff);
      reg_wr(`TMC_OFS_LO, 8'hff);
      compare_reset <= 1'b1;
      @(posedge ref_clk);
      compare_reset <= 1'b0;
      reg_rd(`TMC_OFS_LO, 8'h00);
      reg_rd(`TMC_OFS_HI, 8'h00);
      check({overflow_flag, overflow_irq}, 2'b00);
      $display("Overflow test done");
      n = seed[2:0] + 2;
      reg_rd(`TMC_OFS_LO, 8'h00);
      reg_wr(`TMC_OFS_CTRL, 8'h03);
      tmc_ext_src_inst.pulses(1'b0, n, 35);
      repeat (8) @(posedge ref_clk);
      reg_wr(`TMC_OFS_CTRL, 8'h00);
      reg_rd(`TMC_OFS_LO, n[7:0]);
      reg_wr(`TMC_OFS_CTRL, 8'h08);
      repeat (50) @(posedge ref_clk);
      check(lp_osc_enable, 1'b1);
      reg_wr(`TMC_OFS_LO, 8'h00);
      reg_wr(`TMC_OFS_CTRL, 8'h0f);
      tmc_ext_src_inst.pulses(1'b1, n, 45);
      repeat (8) @(posedge ref_clk);
      reg_wr(`TMC_OFS_CTRL, 8'h00);
      // The line rests low, so the first rise after the write is lost.
      reg_rd(`TMC_OFS_LO, n[7:0] - 8'h01);
      $display("External test done");
      end_of_test();
   end
endmodule : tmc_timer_tb
